// ==== hw/fpc_pkg.sv ====
// shared constants, field layouts and carriers of the float format converter
package fpc_pkg;

    // ------------------------------------------------------------------
    // word layout
    // ------------------------------------------------------------------
    localparam int unsigned WORD_W = 32; // only single precision is handled
    localparam int unsigned EXP_W = 8; // exponent width of both formats
    localparam int unsigned FRAC_W = 23; // stored fraction width

    // ieee word: sign 31, biased exponent 30..23, fraction 22..0
    typedef struct packed {
        logic sign;
        logic [EXP_W-1:0] exp;
        logic [FRAC_W-1:0] frac;
    } ieee_word_t;

    // native word: exponent 31..24, sign 23, fraction 22..0
    typedef struct packed {
        logic [EXP_W-1:0] exp;
        logic sign;
        logic [FRAC_W-1:0] frac;
    } native_word_t;

    // ------------------------------------------------------------------
    // exponent codes
    // ------------------------------------------------------------------
    localparam logic [EXP_W-1:0] IEEE_EXP_SPECIAL = 8'hff; // nan or infinity
    localparam logic [EXP_W-1:0] IEEE_EXP_DENORM = 8'h00; // denormal or zero
    localparam logic [EXP_W-1:0] IEEE_BIAS = 8'h7f; // bias of 127
    localparam logic [EXP_W-1:0] NAT_EXP_ZERO = 8'h80; // -128 marks zero
    localparam logic [EXP_W-1:0] NAT_EXP_MAX = 8'h7f; // saturation exponent
    localparam logic [EXP_W-1:0] NAT_EXP_DENORM = 8'h81; // -127
    localparam logic [EXP_W-1:0] I2N_EXP_ADJ = 8'h81; // e - 127 mod 256
    localparam logic [EXP_W-1:0] POW2_EXP_ADJ = 8'h80; // e + 128 mod 256
    localparam logic [FRAC_W-1:0] FRAC_ONES = 23'h7f_ffff; // largest fraction

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLOCK_PERIOD_NS = 10; // 100 mhz
    localparam int unsigned NAN_PULSE_TENTHS = 15; // 1.5 clock cycles
    localparam logic [1:0] NAN_PULSE_CYCLES =
        2'((NAN_PULSE_TENTHS + 9) / 10); // least time, rounded up
    localparam int unsigned TEST_IR_W = 4; // test instruction width

    // ------------------------------------------------------------------
    // apb register map
    // ------------------------------------------------------------------
    localparam int unsigned APB_ADDR_W = 12;
    localparam logic [APB_ADDR_W-1:0] CTRL_OFFSET = 12'h000;
    localparam logic [APB_ADDR_W-1:0] STATUS_OFFSET = 12'h004;
    localparam logic [WORD_W-1:0] CTRL_RESET = 32'h0000_0001;
    localparam int unsigned CTRL_ENABLE_BIT = 0; // gate on bus driving
    localparam int unsigned STATUS_NAN_BIT = 0; // sticky, write one clears
    localparam int unsigned STATUS_PIPE_BIT = 1; // pipelined mode seen
    localparam int unsigned STATUS_DIR_BIT = 2; // direction seen
    localparam int unsigned STATUS_WAIT_BIT = 3; // access-extend level

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [APB_ADDR_W-1:0] paddr;
        logic [WORD_W-1:0] pwdata;
    } apb_req_t;

    // apb answer to the master
    typedef struct packed {
        logic pready;
        logic [WORD_W-1:0] prdata;
        logic pslverr;
    } apb_rsp_t;

endpackage : fpc_pkg

// ==== hw/ieee_float_format_converter.sv ====
// bidirectional ieee single / native float converter with apb control
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps

module ieee_float_format_converter (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_dir,
    input wire logic i_bus_enable_n,
    input wire logic i_pipe,
    input wire logic [31:0] i_host_side_bus,
    output logic [31:0] o_host_side_bus,
    output logic o_host_side_bus_oe,
    input wire logic [31:0] i_memory_side_bus,
    output logic [31:0] o_memory_side_bus,
    output logic o_memory_side_bus_oe,
    output logic o_wait,
    output logic o_invalid_value_irq_n,
    input wire logic [fpc_pkg::TEST_IR_W-1:0] i_test_ir,
    input wire logic i_test_ir_pause,
    output logic o_test_ir_parity_out,
    input wire fpc_pkg::apb_req_t i_apb,
    output fpc_pkg::apb_rsp_t o_apb
);

    // ------------------------------------------------------------------
    // conversion functions
    // ------------------------------------------------------------------

    // ieee to native; specials saturate, tiny denormals collapse to zero
    function automatic fpc_pkg::native_word_t ieee_to_native(
        input fpc_pkg::ieee_word_t w
    );
        fpc_pkg::native_word_t n;
        logic [fpc_pkg::FRAC_W-1:0] g;
        n.exp = fpc_pkg::NAT_EXP_ZERO;
        n.sign = 1'b0;
        n.frac = '0;
        // denormal fraction shifted up once, hidden one taken by exponent
        g = {w.frac[fpc_pkg::FRAC_W-2:0], 1'b0};
        if (w.exp == fpc_pkg::IEEE_EXP_SPECIAL) begin
            // nan and infinity map to the extreme of their sign
            n.exp = fpc_pkg::NAT_EXP_MAX;
            n.sign = w.sign;
            n.frac = w.sign ? '0 : fpc_pkg::FRAC_ONES;
        end else if (w.exp != fpc_pkg::IEEE_EXP_DENORM) begin
            if (!w.sign) begin
                // positive normal: unbias exponent, keep fraction
                n.exp = w.exp + fpc_pkg::I2N_EXP_ADJ;
                n.frac = w.frac;
            end else if (|w.frac) begin
                // negative normal: mantissa -2 + 0.f' with f' = -f
                n.exp = w.exp + fpc_pkg::I2N_EXP_ADJ;
                n.sign = 1'b1;
                n.frac = ~w.frac + 23'h00_0001;
            end else begin
                // negative power of two: -2 at one exponent lower
                n.exp = w.exp ^ fpc_pkg::POW2_EXP_ADJ;
                n.sign = 1'b1;
            end
        end else if (w.frac[fpc_pkg::FRAC_W-1]) begin
            // denormal of magnitude at least 2^-127
            if (!w.sign) begin
                n.exp = fpc_pkg::NAT_EXP_DENORM;
                n.frac = g;
            end else if (|g) begin
                n.exp = fpc_pkg::NAT_EXP_DENORM;
                n.sign = 1'b1;
                n.frac = ~g + 23'h00_0001;
            end
        end
        // remaining denormals are below reach and become zero
        return n;
    endfunction : ieee_to_native

    // native to ieee; exponent -127 lands in the ieee denormal range
    function automatic fpc_pkg::ieee_word_t native_to_ieee(
        input fpc_pkg::native_word_t n
    );
        fpc_pkg::ieee_word_t w;
        logic [fpc_pkg::FRAC_W-1:0] mag;
        logic [fpc_pkg::EXP_W-1:0] e;
        w = '0;
        mag = n.sign ? (~n.frac + 23'h00_0001) : n.frac;
        e = n.exp + fpc_pkg::IEEE_BIAS;
        if (n.exp == fpc_pkg::NAT_EXP_ZERO) begin
            // zero regardless of sign and fraction
            w = '0;
        end else if (n.sign && n.frac == '0) begin
            // mantissa exactly -2: -1 at the next exponent, may overflow
            w.sign = 1'b1;
            w.exp = n.exp + fpc_pkg::POW2_EXP_ADJ;
        end else begin
            w.sign = n.sign;
            w.exp = e;
            // exponent -127 gives a denormal, lowest bit dropped
            w.frac = (e == fpc_pkg::IEEE_EXP_DENORM) ?
                {1'b1, mag[fpc_pkg::FRAC_W-1:1]} : mag;
        end
        return w;
    endfunction : native_to_ieee

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] ctl_meta_reg; // first stage: dir, enable_n, pipe
    logic [2:0] ctl_reg; // second stage
    logic [31:0] host_meta_reg; // first stage of host bus
    logic [31:0] host_in_reg; // second stage of host bus
    logic [31:0] mem_meta_reg; // first stage of memory bus
    logic [31:0] mem_in_reg; // second stage of memory bus
    logic [fpc_pkg::TEST_IR_W:0] test_meta_reg; // pause and ir, first
    logic [fpc_pkg::TEST_IR_W:0] test_reg; // pause and ir, second

    // two flip-flops on every pin but reset and the apb port before any logic looks at it
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ctl_meta_reg <= 3'h2;
            ctl_reg <= 3'h2;
            host_meta_reg <= '0;
            host_in_reg <= '0;
            mem_meta_reg <= '0;
            mem_in_reg <= '0;
            test_meta_reg <= '0;
            test_reg <= '0;
        end else begin
            ctl_meta_reg <= {i_pipe, i_bus_enable_n, i_dir};
            ctl_reg <= ctl_meta_reg;
            host_meta_reg <= i_host_side_bus;
            host_in_reg <= host_meta_reg;
            mem_meta_reg <= i_memory_side_bus;
            mem_in_reg <= mem_meta_reg;
            test_meta_reg <= {i_test_ir_pause, i_test_ir};
            test_reg <= test_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic [31:0] ctrl_reg; // software control word
    logic [31:0] ctrl_next;
    logic nan_sticky_reg; // nan seen, cleared by software
    logic nan_sticky_next;
    wire dir_s = ctl_reg[0]; // high: memory to host
    wire pipe_s = ctl_reg[2]; // high: pipelined mode
    // bus drive allowed by pin and by software
    wire enable = !ctl_reg[1] && ctrl_reg[fpc_pkg::CTRL_ENABLE_BIT];
    logic enable_prev_reg; // enable one cycle ago
    wire access_start = enable && !enable_prev_reg; // one per access
    wire fpc_pkg::ieee_word_t mem_word = mem_in_reg;
    wire fpc_pkg::native_word_t host_word = host_in_reg;
    wire fpc_pkg::native_word_t conv_i2n = ieee_to_native(mem_word);
    wire fpc_pkg::ieee_word_t conv_n2i = native_to_ieee(host_word);
    // result of the direction now selected
    wire [31:0] conv_sel = dir_s ? conv_i2n : conv_n2i;
    // nan: all-ones exponent and nonzero fraction on the ieee side
    wire is_nan = mem_word.exp == fpc_pkg::IEEE_EXP_SPECIAL
        && |mem_word.frac;
    wire nan_event = access_start && dir_s && is_nan;

    // ------------------------------------------------------------------
    // datapath and bus drive
    // ------------------------------------------------------------------
    logic [31:0] stage_reg; // pipeline stage, converted earlier input
    logic [31:0] out_word_reg; // word driven onto the selected bus
    logic [31:0] out_word_next;
    logic host_oe_reg; // driving host bus
    logic mem_oe_reg; // driving memory bus
    logic wait_reg; // access-extend output

    // pipelined: release the stage on each access; else follow input
    assign out_word_next = pipe_s ?
        (access_start ? stage_reg : out_word_reg) :
        (enable ? conv_sel : out_word_reg);

    // conversion and output register, all on the one clock
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            stage_reg <= '0;
            out_word_reg <= '0;
            enable_prev_reg <= 1'b0;
        end else begin
            enable_prev_reg <= enable;
            out_word_reg <= out_word_next;
            if (access_start) begin
                stage_reg <= conv_sel;
            end
        end
    end

    // bus enables follow direction, released with the enable
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            host_oe_reg <= 1'b0;
            mem_oe_reg <= 1'b0;
        end else begin
            host_oe_reg <= enable && dir_s;
            mem_oe_reg <= enable && !dir_s;
        end
    end

    // one wait state at the start of each non-pipelined access
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            wait_reg <= 1'b0;
        end else begin
            wait_reg <= access_start && !pipe_s;
        end
    end

    // ------------------------------------------------------------------
    // nan interrupt pulse
    // ------------------------------------------------------------------
    logic [1:0] nan_cnt_reg; // cycles of low left
    logic [1:0] nan_cnt_next;
    logic irq_n_reg; // interrupt output, active low

    assign nan_cnt_next = nan_event ? fpc_pkg::NAN_PULSE_CYCLES :
        (nan_cnt_reg != 2'h0) ? nan_cnt_reg - 2'h1 : 2'h0;

    // low for whole cycles covering the one and a half cycle pulse
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            nan_cnt_reg <= 2'h0;
            irq_n_reg <= 1'b1;
        end else begin
            nan_cnt_reg <= nan_cnt_next;
            irq_n_reg <= nan_cnt_next == 2'h0;
        end
    end

    // ------------------------------------------------------------------
    // test instruction parity
    // ------------------------------------------------------------------
    logic parity_reg; // parity output, low when not paused

    // even parity bit: xor of the instruction while paused
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            parity_reg <= 1'b0;
        end else begin
            parity_reg <= test_reg[fpc_pkg::TEST_IR_W] &&
                (^test_reg[fpc_pkg::TEST_IR_W-1:0]);
        end
    end

    // ------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------
    fpc_pkg::apb_rsp_t apb_rsp_reg; // registered answer
    wire apb_setup = i_apb.psel && !i_apb.penable;
    wire apb_commit = i_apb.psel && i_apb.penable && apb_rsp_reg.pready;
    wire hit_ctrl = i_apb.paddr == fpc_pkg::CTRL_OFFSET;
    wire hit_status = i_apb.paddr == fpc_pkg::STATUS_OFFSET;
    wire [31:0] status_word = {28'h000_0000, wait_reg, dir_s, pipe_s,
        nan_sticky_reg};
    wire [31:0] read_word = hit_ctrl ? ctrl_reg :
        hit_status ? status_word : 32'h0000_0000;
    wire nan_clear = apb_commit && i_apb.pwrite && hit_status &&
        i_apb.pwdata[fpc_pkg::STATUS_NAN_BIT];

    assign ctrl_next = (apb_commit && i_apb.pwrite && hit_ctrl) ?
        (i_apb.pwdata & fpc_pkg::CTRL_RESET) : ctrl_reg;
    // a nan in the clearing cycle keeps the flag set
    assign nan_sticky_next = nan_event || (nan_sticky_reg && !nan_clear);

    // answer in the first access cycle; unmapped gives an error
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            apb_rsp_reg <= '0;
            ctrl_reg <= fpc_pkg::CTRL_RESET;
            nan_sticky_reg <= 1'b0;
        end else begin
            apb_rsp_reg.pready <= apb_setup;
            if (apb_setup) begin
                apb_rsp_reg.prdata <= i_apb.pwrite ? '0 : read_word;
                apb_rsp_reg.pslverr <= !(hit_ctrl || hit_status);
            end
            ctrl_reg <= ctrl_next;
            nan_sticky_reg <= nan_sticky_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign o_host_side_bus = out_word_reg;
    assign o_memory_side_bus = out_word_reg;
    assign o_host_side_bus_oe = host_oe_reg;
    assign o_memory_side_bus_oe = mem_oe_reg;
    assign o_wait = wait_reg;
    assign o_invalid_value_irq_n = irq_n_reg;
    assign o_test_ir_parity_out = parity_reg;
    assign o_apb = apb_rsp_reg;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    sequence s_one_wait;
        wait_reg ##1 !wait_reg;
    endsequence

    property p_wait_pipe_low;
        $past(pipe_s) |-> !wait_reg;
    endproperty
    a_wait_pipe_low: assert property (p_wait_pipe_low)
        else $error("wait high in pipelined mode");

    property p_wait_on_access;
        access_start && !pipe_s |=> s_one_wait;
    endproperty
    a_wait_on_access: assert property (p_wait_on_access)
        else $error("non-pipelined access without one wait state");

    property p_host_drive;
        enable && dir_s |=> host_oe_reg && !mem_oe_reg;
    endproperty
    a_host_drive: assert property (p_host_drive)
        else $error("host bus not driven for ieee to native");

    property p_mem_drive;
        enable && !dir_s |=> mem_oe_reg && !host_oe_reg;
    endproperty
    a_mem_drive: assert property (p_mem_drive)
        else $error("memory bus not driven for native to ieee");

    property p_release;
        !enable |=> !host_oe_reg && !mem_oe_reg;
    endproperty
    a_release: assert property (p_release)
        else $error("bus still driven after enable release");

    property p_nan_pulse;
        nan_event |=> !irq_n_reg [*2];
    endproperty
    a_nan_pulse: assert property (p_nan_pulse)
        else $error("nan interrupt pulse too short");

    property p_pipe_skew;
        access_start && pipe_s |=> out_word_reg == $past(stage_reg);
    endproperty
    a_pipe_skew: assert property (p_pipe_skew)
        else $error("pipelined output not previous conversion");

    property p_direct_conv;
        enable && !pipe_s |=> out_word_reg == $past(conv_sel);
    endproperty
    a_direct_conv: assert property (p_direct_conv)
        else $error("non-pipelined output not the conversion");

    property p_parity;
        test_reg[fpc_pkg::TEST_IR_W] |=>
            parity_reg == ^$past(test_reg[fpc_pkg::TEST_IR_W-1:0]);
    endproperty
    a_parity: assert property (p_parity)
        else $error("test parity wrong while paused");

    property p_native_zero;
        host_word.exp == fpc_pkg::NAT_EXP_ZERO |-> conv_n2i == '0;
    endproperty
    a_native_zero: assert property (p_native_zero)
        else $error("native zero not converted to ieee zero");

endmodule : ieee_float_format_converter

// ==== verification/memory_side_model.sv ====
// memory array model on the ieee side of the converter
`timescale 1ns/100ps

module memory_side_model (
    input wire logic i_clock,
    input wire logic i_dir,
    input wire logic i_bus_enable_n,
    input wire logic [31:0] i_word,
    input wire logic i_dev_oe,
    input wire logic [31:0] i_dev_word,
    output logic [31:0] o_bus,
    output logic [31:0] o_stored
);
    // ------------------------------------------------------------------
    // bus level and storage
    // ------------------------------------------------------------------
    logic [31:0] last_reg = 32'h0000_0000; // last level seen on the bus
    // memory answers reads; an undriven bus shows a toggling pattern
    assign o_bus = i_dev_oe ? i_dev_word
        : (i_dir && !i_bus_enable_n) ? i_word : ~last_reg;
    // memory takes the converted word while the device drives it
    always_ff @(posedge i_clock) begin
        last_reg <= o_bus;
        if (i_dev_oe && !i_bus_enable_n) begin
            o_stored <= i_dev_word;
        end
    end
endmodule : memory_side_model

// ==== verification/tb_ieee_float_format_converter.sv ====
// self-checking bench of the float format converter
`timescale 1ns/100ps

module tb_ieee_float_format_converter;
    // ------------------------------------------------------------------
    // stimulus, observation and tables
    // ------------------------------------------------------------------
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic dir_pin = 1'b1;
    logic en_n = 1'b1;
    logic pipe_pin = 1'b0;
    logic [31:0] host_drv = 32'h0000_0000; // host side drive
    logic [31:0] mem_word = 32'h0000_0000; // word the memory returns
    logic [3:0] ir = 4'h0;
    logic ir_pause = 1'b0;
    fpc_pkg::apb_req_t apb_req = '0;
    fpc_pkg::apb_rsp_t o_apb;
    logic [31:0] o_host, o_mem, host_bus, mem_bus, stored, rd;
    logic host_oe, mem_oe, o_wait, irq_n, parity, err;
    int n_errors = 0;
    int samples_checked = 0;
    // ieee word, native image pairs
    localparam logic [31:0] I2N [0:23] = '{
        32'h3F80_0000, 32'h0000_0000, 32'hBF80_0000, 32'hFF80_0000,
        32'h4040_0000, 32'h0140_0000, 32'hC040_0000, 32'h01C0_0000,
        32'h0000_0000, 32'h8000_0000, 32'h8000_0000, 32'h8000_0000,
        32'h0040_0000, 32'h8100_0000, 32'h0000_0001, 32'h8000_0000,
        32'h7F80_0000, 32'h7F7F_FFFF, 32'hFF80_0000, 32'h7F80_0000,
        32'h7FC0_0000, 32'h7F7F_FFFF, 32'hFFC0_0001, 32'h7F80_0000};
    // native word, ieee image pairs
    localparam logic [31:0] N2I [0:11] = '{
        32'h0000_0000, 32'h3F80_0000, 32'hFF80_0000, 32'hBF80_0000,
        32'h01C0_0000, 32'hC040_0000, 32'h8000_0000, 32'h0000_0000,
        32'h8055_1234, 32'h0000_0000, 32'h7F80_0000, 32'hFF80_0000};

    // host bus level: device when it drives, host otherwise
    assign host_bus = host_oe ? o_host : host_drv;

    initial begin
        forever #5 i_clock = ~i_clock;
    end

    ieee_float_format_converter dut_u (
        .i_clock(i_clock), .i_rst(i_rst), .i_dir(dir_pin),
        .i_bus_enable_n(en_n), .i_pipe(pipe_pin),
        .i_host_side_bus(host_bus), .o_host_side_bus(o_host),
        .o_host_side_bus_oe(host_oe), .i_memory_side_bus(mem_bus),
        .o_memory_side_bus(o_mem), .o_memory_side_bus_oe(mem_oe),
        .o_wait(o_wait), .o_invalid_value_irq_n(irq_n), .i_test_ir(ir),
        .i_test_ir_pause(ir_pause), .o_test_ir_parity_out(parity),
        .i_apb(apb_req), .o_apb(o_apb));

    memory_side_model mem_u (
        .i_clock(i_clock), .i_dir(dir_pin), .i_bus_enable_n(en_n),
        .i_word(mem_word), .i_dev_oe(mem_oe), .i_dev_word(o_mem),
        .o_bus(mem_bus), .o_stored(stored));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        apb_req <= '{1'b1, 1'b0, wr, a, wd};
        @(posedge i_clock);
        apb_req.penable <= 1'b1;
        // only the watchdog ends a wait that never gets an answer
        do begin
            @(posedge i_clock);
        end while (o_apb.pready !== 1'b1);
        rd = o_apb.prdata;
        err = o_apb.pslverr;
        chk("pready", 32'h1, {31'h0, o_apb.pready});
        apb_req <= '0;
        @(posedge i_clock);
    endtask : apb

    // one strobed conversion access, then release of the bus
    task automatic access(input logic d, input logic [31:0] w,
                          input logic [31:0] exp, input int waits,
                          input int lows, input logic cmp);
        int nw;
        int nl;
        nw = 0;
        nl = 0;
        dir_pin <= d;
        mem_word <= w;
        host_drv <= d ? ~host_drv : w;
        @(posedge i_clock);
        en_n <= 1'b0;
        repeat (8) begin
            @(posedge i_clock);
            nw += int'(o_wait === 1'b1);
            nl += int'(irq_n === 1'b0);
        end
        chk("wait_cycles", 32'(waits), 32'(nw));
        chk("irq_low_cycles", 32'(lows), 32'(nl));
        chk("driven_oe", 32'h1, {31'h0, d ? host_oe : mem_oe});
        chk("idle_oe", 32'h0, {31'h0, d ? mem_oe : host_oe});
        if (cmp) begin
            chk("word", exp, d ? host_bus : stored);
        end
        en_n <= 1'b1;
        repeat (5) @(posedge i_clock);
        chk("released_oe", 32'h0, {30'h0, host_oe, mem_oe});
    endtask : access

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        i_rst <= 1'b1;
        repeat (10) @(posedge i_clock);
        i_rst <= 1'b0;
        @(posedge i_clock);
        chk("reset_pins", 32'h2, {27'h0, host_oe, mem_oe, o_wait, irq_n,
            parity});
        apb(1'b0, fpc_pkg::CTRL_OFFSET, 32'h0000_0000);
        chk("ctrl_reset", fpc_pkg::CTRL_RESET, rd);
        $display("test reset done");
    endtask : t_reset

    task automatic t_i2n();
        logic [31:0] w;
        for (int i = 0; i < 24; i += 2) begin
            w = I2N[i];
            access(1'b1, w, I2N[i+1], 1, (w[30:23] == 8'hFF &&
                w[22:0] != 23'h0) ? int'(fpc_pkg::NAN_PULSE_CYCLES) : 0,
                1'b1);
        end
        apb(1'b0, fpc_pkg::STATUS_OFFSET, 32'h0000_0000);
        chk("status_nan", 32'h1, {31'h0, rd[0]});
        apb(1'b1, fpc_pkg::STATUS_OFFSET, 32'h0000_0001);
        apb(1'b0, fpc_pkg::STATUS_OFFSET, 32'h0000_0000);
        chk("status_cleared", 32'h0, {31'h0, rd[0]});
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk("unmapped_err", 32'h1, {31'h0, err});
        $display("test ieee to native done");
    endtask : t_i2n

    task automatic t_n2i();
        for (int i = 0; i < 12; i += 2) begin
            access(1'b0, N2I[i], N2I[i+1], 1, 0, 1'b1);
        end
        $display("test native to ieee done");
    endtask : t_n2i

    task automatic t_pipe();
        pipe_pin <= 1'b1;
        repeat (4) @(posedge i_clock);
        access(1'b1, 32'h3F80_0000, 32'h0, 0, 0, 1'b0);
        access(1'b1, 32'h4040_0000, 32'h0000_0000, 0, 0, 1'b1);
        access(1'b1, 32'h4040_0000, 32'h0140_0000, 0, 0, 1'b1);
        apb(1'b0, fpc_pkg::STATUS_OFFSET, 32'h0000_0000);
        chk("status_pipe", 32'h1, {31'h0, rd[1]});
        chk("status_dir", 32'h1, {31'h0, rd[2]});
        pipe_pin <= 1'b0;
        repeat (4) @(posedge i_clock);
        $display("test pipeline done");
    endtask : t_pipe

    task automatic t_parity();
        ir <= 4'hB;
        ir_pause <= 1'b1;
        repeat (5) @(posedge i_clock);
        chk("parity_paused", 32'h1, {31'h0, parity});
        ir_pause <= 1'b0;
        repeat (5) @(posedge i_clock);
        chk("parity_running", 32'h0, {31'h0, parity});
        $display("test parity done");
    endtask : t_parity

    task automatic t_ctrl();
        apb(1'b1, fpc_pkg::CTRL_OFFSET, 32'h0000_0000);
        dir_pin <= 1'b1;
        en_n <= 1'b0;
        repeat (6) @(posedge i_clock);
        chk("gated_oe", 32'h0, {30'h0, host_oe, mem_oe});
        en_n <= 1'b1;
        repeat (2) @(posedge i_clock);
        t_reset();
        $display("test drive gate done");
    endtask : t_ctrl

    initial begin
        @(posedge i_clock);
        t_reset();
        t_i2n();
        t_n2i();
        t_pipe();
        t_parity();
        t_ctrl();
        tally_and_finish();
    end

    // cut a hang short
    initial begin
        repeat (5000) @(posedge i_clock);
        n_errors++;
        tally_and_finish();
    end
endmodule : tb_ieee_float_format_converter
